/* File: shared/hlbc_pkg.sv */
// constants and types for the haptic loop and brake control block
// assumes a single 100 MHz system clock shared by all users of this package
package hlbc_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] HLBC_ADDR_LOOP = 8'h08;
   localparam logic [7:0] HLBC_ADDR_SUPPLY = 8'h09;
   localparam logic [7:0] HLBC_LOOP_RST = 8'h88;
   localparam logic [7:0] HLBC_SUPPLY_RST = 8'h00;
   localparam logic [7:0] HLBC_RDATA_NONE = 8'h00;
   // ==========================================================
   // field positions of the loop register
   localparam int HLBC_ACT_LRA_BIT = 7;
   localparam int HLBC_OPEN_BIT = 6;
   localparam int HLBC_HYBRID_BIT = 5;
   localparam int HLBC_OLBRK_BIT = 4;
   localparam int HLBC_IDLEBRK_BIT = 3;
   localparam int HLBC_SLOPE_BIT = 2;
   // ==========================================================
   // field positions of the supply register
   localparam int HLBC_SAG_LSB = 6;
   localparam int HLBC_SAG_MSB = 7;
   localparam int HLBC_UV_LSB = 0;
   localparam int HLBC_UV_MSB = 2;
   // ==========================================================
   // step-size gate threshold on sample magnitude change
   localparam logic [8:0] HLBC_STEP_THRESH = 9'h020;
   // ==========================================================
   // timing
   localparam int HLBC_CLK_PERIOD_NS = 10;
   localparam int HLBC_BRAKE_MAX_NS = 10000;
   localparam logic [9:0] HLBC_BRAKE_MAX_CYC = 10'(HLBC_BRAKE_MAX_NS / HLBC_CLK_PERIOD_NS);
   // ==========================================================
   // standby sequencer states
   typedef enum logic [1:0] {HLBC_S_RUN, HLBC_S_CHECK, HLBC_S_BRAKE, HLBC_S_STBY} hlbc_stby_state_t;
endpackage

/* File: verilog/hlbc_idle_brake.sv */
// standby entry sequencer with optional brake-before-idle
// assumes idle_req, moving and wake come from logic on sys_clk
module hlbc_idle_brake (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic brake_en, // brake before idle enabled
   input wire logic playing, // waveform is playing
   input wire logic moving, // actuator motion detected
   input wire logic idle_req, // go-to-standby request pulse
   input wire logic wake, // leave standby
   output logic brake_q, // standby brake active
   output logic standby_q // device in standby
);
   import hlbc_pkg::*;

   hlbc_stby_state_t state_q, state_d;
   logic [9:0] cnt_q, cnt_d;

   // ==========================================================
   // next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         HLBC_S_RUN: begin
            cnt_d = 10'h000;
            if (idle_req) begin
               if (brake_en && playing) begin
                  state_d = HLBC_S_CHECK;
               end else begin
                  state_d = HLBC_S_STBY;
               end
            end
         end
         HLBC_S_CHECK: begin
            // brake only a moving actuator
            state_d = moving ? HLBC_S_BRAKE : HLBC_S_STBY;
         end
         HLBC_S_BRAKE: begin
            // capped so a stuck motion sensor cannot hold off standby
            cnt_d = cnt_q + 10'h001;
            if (!moving || cnt_q >= HLBC_BRAKE_MAX_CYC - 10'h001) begin
               state_d = HLBC_S_STBY;
            end
         end
         HLBC_S_STBY: begin
            if (wake) begin
               state_d = HLBC_S_RUN;
            end
         end
         default: state_d = HLBC_S_RUN;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= HLBC_S_RUN;
         cnt_q <= 10'h000;
         brake_q <= 1'b0;
         standby_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         brake_q <= (state_d == HLBC_S_BRAKE);
         standby_q <= (state_d == HLBC_S_STBY);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_check_entry;
      state_q == HLBC_S_RUN && ce && idle_req && brake_en && playing;
   endsequence

   chk_idle_direct: assert property (state_q == HLBC_S_RUN && ce && idle_req && !brake_en
      |=> standby_q && !brake_q) else $error("standby not entered directly");
   chk_brake_check: assert property (seq_check_entry ##1 (ce && moving)
      |=> brake_q && !standby_q) else $error("moving actuator not braked");
   chk_still_skip: assert property (seq_check_entry ##1 (ce && !moving)
      |=> standby_q && !brake_q) else $error("still actuator braked");
   chk_brake_bound: assert property (cnt_q <= HLBC_BRAKE_MAX_CYC)
      else $error("standby brake ran too long");
endmodule

/* File: verilog/hlbc_top.sv */
// haptic loop and brake control: config registers and loop selection
// assumes a byte register port behind the serial interface, on sys_clk
module hlbc_top (
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [7:0] reg_rdata_q, // register read data
   input wire logic sample_valid, // new sample to play
   input wire logic signed [7:0] sample_data, // signed sample value
   input wire logic playing, // waveform playing
   input wire logic actuator_moving, // motion detected
   input wire logic idle_timer_expired, // idle timer standby request
   input wire logic trigger_irq_pin, // trigger pin level, asynchronous
   input wire logic trig_level_mode, // trigger pin in level-enable mode
   input wire logic wake_req, // leave standby
   output logic actuator_lra_q, // actuator type select
   output logic loop_closed_q, // drive loop closed for current sample
   output logic hybrid_q, // hybrid closed loop active
   output logic sample_brake_q, // active brake for current sample
   output logic [1:0] supply_sag_clamp_en_q, // supply protection level enable
   output logic [2:0] undervoltage_cutoff_sel_q, // undervoltage threshold select
   output logic idle_brake_q, // braking before standby
   output logic standby_q // in standby
);
   import hlbc_pkg::*;

   logic [7:0] loop_cfg_q, loop_cfg_d;
   logic [7:0] supply_cfg_q, supply_cfg_d;
   logic [7:0] rdata_d;
   logic loop_wr_seen_q, loop_wr_seen_d;
   logic open_sel, hybrid_sel, olbrk_en, slope_en;
   logic loop_closed_d, hybrid_d, sample_brake_d;
   logic signed [7:0] prev_sample_q, prev_sample_d;
   logic signed [8:0] step_diff;
   logic [8:0] step_mag;
   logic step_large;
   logic pin_meta_q, pin_sync_q, pin_prev_q;
   logic idle_req;

   // ==========================================================
   // register port
   assign open_sel = loop_cfg_q[HLBC_OPEN_BIT];
   assign hybrid_sel = loop_cfg_q[HLBC_HYBRID_BIT];
   assign olbrk_en = loop_cfg_q[HLBC_OLBRK_BIT];
   assign slope_en = loop_cfg_q[HLBC_SLOPE_BIT];

   always_comb begin
      loop_cfg_d = loop_cfg_q;
      supply_cfg_d = supply_cfg_q;
      loop_wr_seen_d = loop_wr_seen_q;
      rdata_d = reg_rdata_q;
      if (reg_wr && reg_addr == HLBC_ADDR_LOOP) begin
         // reserved bits are plain read/write storage
         loop_cfg_d = reg_wdata;
         loop_wr_seen_d = 1'b1;
      end
      if (reg_wr && reg_addr == HLBC_ADDR_SUPPLY) begin
         supply_cfg_d = reg_wdata;
      end
      if (reg_rd) begin
         case (reg_addr)
            HLBC_ADDR_LOOP: rdata_d = loop_cfg_q;
            HLBC_ADDR_SUPPLY: rdata_d = supply_cfg_q;
            default: rdata_d = HLBC_RDATA_NONE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loop_cfg_q <= HLBC_LOOP_RST;
         supply_cfg_q <= HLBC_SUPPLY_RST;
         loop_wr_seen_q <= 1'b0;
         reg_rdata_q <= HLBC_RDATA_NONE;
      end else if (ce) begin
         loop_cfg_q <= loop_cfg_d;
         supply_cfg_q <= supply_cfg_d;
         loop_wr_seen_q <= loop_wr_seen_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // per-sample loop selection
   // step measured against the previous sample, not the played level
   assign step_diff = {sample_data[7], sample_data} - {prev_sample_q[7], prev_sample_q};
   assign step_mag = step_diff[8] ? 9'(-step_diff) : 9'(step_diff);
   assign step_large = (step_mag >= HLBC_STEP_THRESH);

   always_comb begin
      loop_closed_d = loop_closed_q;
      hybrid_d = hybrid_q;
      sample_brake_d = sample_brake_q;
      prev_sample_d = prev_sample_q;
      if (sample_valid) begin
         prev_sample_d = sample_data;
         sample_brake_d = 1'b0;
         hybrid_d = 1'b0;
         if (open_sel) begin
            // calibration is the host's duty before setting olbrk_en
            if (olbrk_en && sample_data <= 8'sh00) begin
               loop_closed_d = 1'b1;
               sample_brake_d = 1'b1;
            end else begin
               loop_closed_d = 1'b0;
            end
         end else if (hybrid_sel) begin
            hybrid_d = 1'b1;
            loop_closed_d = slope_en ? step_large : 1'b1;
         end else begin
            loop_closed_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loop_closed_q <= 1'b1;
         hybrid_q <= 1'b0;
         sample_brake_q <= 1'b0;
         prev_sample_q <= 8'sh00;
      end else if (ce) begin
         loop_closed_q <= loop_closed_d;
         hybrid_q <= hybrid_d;
         sample_brake_q <= sample_brake_d;
         prev_sample_q <= prev_sample_d;
      end
   end

   // ==========================================================
   // config outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         actuator_lra_q <= HLBC_LOOP_RST[HLBC_ACT_LRA_BIT];
         supply_sag_clamp_en_q <= HLBC_SUPPLY_RST[HLBC_SAG_MSB:HLBC_SAG_LSB];
         undervoltage_cutoff_sel_q <= HLBC_SUPPLY_RST[HLBC_UV_MSB:HLBC_UV_LSB];
      end else if (ce) begin
         actuator_lra_q <= loop_cfg_d[HLBC_ACT_LRA_BIT];
         supply_sag_clamp_en_q <= supply_cfg_d[HLBC_SAG_MSB:HLBC_SAG_LSB];
         undervoltage_cutoff_sel_q <= supply_cfg_d[HLBC_UV_MSB:HLBC_UV_LSB];
      end
   end

   // ==========================================================
   // standby requests: timer, or trigger pin released in level mode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else if (ce) begin
         pin_meta_q <= trigger_irq_pin;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   assign idle_req = idle_timer_expired || (trig_level_mode && pin_prev_q && !pin_sync_q);

   hlbc_idle_brake u_idle (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .brake_en(loop_cfg_q[HLBC_IDLEBRK_BIT]),
      .playing(playing),
      .moving(actuator_moving),
      .idle_req(idle_req),
      .wake(wake_req),
      .brake_q(idle_brake_q),
      .standby_q(standby_q)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_ol_brake_neg: assert property (ce && sample_valid && open_sel && olbrk_en && sample_data <= 8'sh00
      |=> loop_closed_q && sample_brake_q) else $error("nonpositive sample not braked");
   chk_ol_pos_open: assert property (ce && sample_valid && open_sel && sample_data > 8'sh00
      |=> !loop_closed_q && !sample_brake_q) else $error("positive sample left open loop");
   chk_closed_sel: assert property (ce && sample_valid && !open_sel && !hybrid_sel
      |=> loop_closed_q && !hybrid_q) else $error("full closed loop not selected");
   chk_hybrid_sel: assert property (ce && sample_valid && !open_sel && hybrid_sel && !slope_en
      |=> hybrid_q && loop_closed_q) else $error("hybrid loop not selected");
   chk_step_gate: assert property (ce && sample_valid && !open_sel && hybrid_sel && slope_en
      |=> loop_closed_q == $past(step_large)) else $error("step gate wrong");
   chk_gate_ignored: assert property (ce && sample_valid && !open_sel && !hybrid_sel && slope_en && !step_large
      |=> loop_closed_q) else $error("step gate acted without hybrid");
   chk_olbrk_reset: assert property (!loop_wr_seen_q |-> !olbrk_en && loop_cfg_q[HLBC_IDLEBRK_BIT])
      else $error("loop register reset value wrong");
   // idle, still actuator and no brake pending: a level release must reach standby next edge
   chk_pin_idle: assert property (ce && trig_level_mode && pin_prev_q && !pin_sync_q && !actuator_moving
      && (!playing || !loop_cfg_q[HLBC_IDLEBRK_BIT]) && !standby_q && !idle_brake_q
      |=> standby_q) else $error("level release did not request standby");
endmodule

/* File: sim/hlbc_host.sv */
// host side of the byte register port, standing in for the serial engine
// assumes the port takes one strobe per rising edge of sys_clk
module hlbc_host (
   input wire logic sys_clk, // system clock
   input wire logic [7:0] reg_rdata_q, // read data from the block
   output logic [7:0] reg_addr, // register address
   output logic [7:0] reg_wdata, // write data
   output logic reg_wr, // write strobe
   output logic reg_rd // read strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // ==========================================================
   // bus cycles; released lines show inverted values, not stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      d = reg_rdata_q;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

/* File: sim/hlbc_top_tb.sv */
// self-checking bench for the loop and brake control block
// assumes the host model above drives the register port
module hlbc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import hlbc_pkg::*;
   typedef struct {logic [7:0] cfg; logic [7:0] smp; logic [2:0] exp;} hlbc_tb_row_t;
   logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sample_valid = 1'b0, playing = 1'b0;
   logic actuator_moving = 1'b0, idle_timer_expired = 1'b0, trigger_irq_pin = 1'b1;
   logic trig_level_mode = 1'b0, wake_req = 1'b0, reg_wr, reg_rd;
   logic [7:0] sample_data = 8'h00, reg_addr, reg_wdata, reg_rdata_q, rd_v;
   logic actuator_lra_q, loop_closed_q, hybrid_q, sample_brake_q, idle_brake_q, standby_q;
   logic [1:0] sag;
   logic [2:0] uv;
   int n_mismatch = 0, checked = 0, cnt;
   hlbc_tb_row_t rows [11];
   always #5 sys_clk = ~sys_clk;
   hlbc_host host_u (.sys_clk(sys_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   hlbc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
      .sample_data(sample_data), .playing(playing), .actuator_moving(actuator_moving),
      .idle_timer_expired(idle_timer_expired), .trigger_irq_pin(trigger_irq_pin),
      .trig_level_mode(trig_level_mode), .wake_req(wake_req), .actuator_lra_q(actuator_lra_q),
      .loop_closed_q(loop_closed_q), .hybrid_q(hybrid_q), .sample_brake_q(sample_brake_q),
      .supply_sag_clamp_en_q(sag), .undervoltage_cutoff_sel_q(uv), .idle_brake_q(idle_brake_q),
      .standby_q(standby_q));
   // ==========================================================
   // helpers
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic idle_pulse();
      idle_timer_expired = 1'b1;
      step();
      idle_timer_expired = 1'b0;
   endtask
   task automatic wake_up();
      wake_req = 1'b1;
      step();
      wake_req = 1'b0;
      chk8({7'h00, standby_q}, 8'h00);
   endtask
   initial begin
      // closed-loop rows come before any open-loop braking is enabled
      rows[0] = '{8'h00, 8'h60, 3'b100};
      rows[1] = '{8'h04, 8'h64, 3'b100};
      rows[2] = '{8'h24, 8'h65, 3'b010};
      rows[3] = '{8'h24, 8'hec, 3'b110};
      rows[4] = '{8'h24, 8'h0b, 3'b010};
      rows[5] = '{8'h24, 8'h2b, 3'b110};
      rows[6] = '{8'h20, 8'h2b, 3'b110};
      rows[7] = '{8'h40, 8'hfd, 3'b000};
      rows[8] = '{8'h50, 8'h00, 3'b101};
      rows[9] = '{8'h50, 8'hfd, 3'b101};
      rows[10] = '{8'h50, 8'h01, 3'b000};
      repeat (16) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      chk8({5'h00, loop_closed_q, hybrid_q, sample_brake_q}, 8'h04);
      chk8({7'h00, actuator_lra_q}, 8'h01);
      chk8({3'h0, sag, uv}, 8'h00);
      host_u.rd(HLBC_ADDR_LOOP, rd_v);
      chk8(rd_v, 8'h88);
      host_u.rd(HLBC_ADDR_SUPPLY, rd_v);
      chk8(rd_v, 8'h00);
      $display("test reset done");
      // ==========================================================
      // table: config, sample, then loop decision
      foreach (rows[i]) begin
         host_u.wr(HLBC_ADDR_LOOP, rows[i].cfg);
         sample_data = rows[i].smp;
         sample_valid = 1'b1;
         step();
         sample_valid = 1'b0;
         chk8({7'h00, loop_closed_q}, {7'h00, rows[i].exp[2]});
         chk8({7'h00, sample_brake_q}, {7'h00, rows[i].exp[0]});
         // hybrid flag is checked only while the loop bit selects closed loop
         if (!rows[i].cfg[HLBC_OPEN_BIT]) chk8({7'h00, hybrid_q}, {7'h00, rows[i].exp[1]});
      end
      chk8({7'h00, actuator_lra_q}, 8'h00);
      $display("test sample table done");
      // ==========================================================
      // supply register, reserved bits, unmapped address
      host_u.wr(HLBC_ADDR_SUPPLY, 8'hed);
      chk8({3'h0, sag, uv}, 8'h1d);
      host_u.wr(8'h0a, 8'h77);
      host_u.rd(HLBC_ADDR_SUPPLY, rd_v);
      chk8(rd_v, 8'hed);
      host_u.rd(8'h0a, rd_v);
      chk8(rd_v, HLBC_RDATA_NONE);
      // a write while the clock enable is low must be lost
      ce = 1'b0;
      host_u.wr(HLBC_ADDR_SUPPLY, 8'h12);
      ce = 1'b1;
      host_u.rd(HLBC_ADDR_SUPPLY, rd_v);
      chk8(rd_v, 8'hed);
      $display("test registers done");
      // ==========================================================
      // standby entry with brake-before-idle set, then with it cleared
      host_u.wr(HLBC_ADDR_LOOP, 8'h08);
      playing = 1'b1;
      actuator_moving = 1'b1;
      idle_pulse();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h00);
      step();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h02);
      cnt = 1;
      while (idle_brake_q === 1'b1 && cnt < 1100) begin
         step();
         cnt++;
      end
      // brake capped near the cap count while motion persists
      chk8({7'h00, cnt >= 999 && cnt <= 1001}, 8'h01);
      chk8({7'h00, standby_q}, 8'h01);
      wake_up();
      idle_pulse();
      step();
      actuator_moving = 1'b0;
      step();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h01);
      wake_up();
      idle_pulse();
      step();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h01);
      wake_up();
      playing = 1'b0;
      actuator_moving = 1'b1;
      idle_pulse();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h01);
      wake_up();
      host_u.wr(HLBC_ADDR_LOOP, 8'h00);
      playing = 1'b1;
      idle_pulse();
      chk8({6'h00, idle_brake_q, standby_q}, 8'h01);
      wake_up();
      $display("test standby done");
      // ==========================================================
      // standby request from the trigger pin in level-enable mode
      trig_level_mode = 1'b1;
      actuator_moving = 1'b0;
      repeat (4) step();
      trigger_irq_pin = 1'b0;
      cnt = 0;
      while (standby_q !== 1'b1 && cnt < 8) begin
         step();
         cnt++;
      end
      chk8({7'h00, standby_q}, 8'h01);
      if (standby_q !== 1'b1) wrap_up();
      wake_up();
      $display("test trigger done");
      // ==========================================================
      // reset in mid-run restores the loop register
      rst_n = 1'b0;
      step();
      rst_n = 1'b1;
      chk8({7'h00, actuator_lra_q}, 8'h01);
      host_u.rd(HLBC_ADDR_LOOP, rd_v);
      chk8(rd_v, 8'h88);
      $display("test mid reset done");
      wrap_up();
   end
endmodule
